// ==== logic/dpt_defines.svh ====
`ifndef DPT_DEFINES_SVH
`define DPT_DEFINES_SVH

// ----------------------------------------------------------------
// source selection of the wide timer
// ----------------------------------------------------------------
`define DPT_SRC_DIV1        3'h0
`define DPT_SRC_DIV2        3'h1
`define DPT_SRC_DIV4        3'h2
`define DPT_SRC_DIV8        3'h3
`define DPT_SRC_SLOW        3'h4

// ----------------------------------------------------------------
// narrow timer period minimum, prescaler width and wide source select msb
// ----------------------------------------------------------------
`define DPT_NARROW_MIN_PER  14'h0002
`define DPT_PRE_W           3
`define DPT_SEL_MSB         2

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define DPT_RST_WIDE_CNT    16'h0000
`define DPT_RST_NARROW_CNT  14'h0000
`define DPT_RST_PRE         3'h0

`endif

// ==== logic/dpt_pkg.sv ====
package dpt_pkg;

    // one-hot phase of the wide timer
    typedef enum logic [2:0] {
        DPT_WIDE_IDLE = 3'b001,
        DPT_WIDE_HIGH = 3'b010,
        DPT_WIDE_LOW  = 3'b100
    } dpt_wide_e;

    // prescaler count shared by both timers
    typedef logic [2:0] dpt_pre_t;

endpackage : dpt_pkg

// ==== logic/dpt_top.sv ====
`timescale 1ns/1ns
`include "dpt_defines.svh"

// How it works
// - wide timer counts with a 16-bit counter; high and low reloads use full range.
// - both wide outputs carry the same wave from one set of settings.
// - wide period is (high+1)+(low+1) source ticks; source is clock/1,2,4,8 or slow tick.
// - wide duty is (high+1) over the whole period.
// - separate interrupt timer fires every (interrupt period+1) source ticks.
// - narrow timer is built on a 14-bit counter.
// - narrow timer drives three outputs from one common period counter.
// - narrow input tick is system clock or slow tick divided by 1, 2, 4 or 8.
// - narrow period spans 2 up to 16383 input ticks.
// - each narrow output has own duty, from always low to always high.
module dpt_top #(
    parameter int WIDE_W   = 16,
    parameter int NARROW_W = 14
) (
    input  wire logic                clk_in,
    input  wire logic                rst_n_in,
    input  wire logic                slow_tick_in,
    input  wire logic                wide_en_in,
    input  wire logic [2:0]          wide_src_sel_in,
    input  wire logic [WIDE_W-1:0]   wide_high_in,
    input  wire logic [WIDE_W-1:0]   wide_low_in,
    input  wire logic                wide_irq_en_in,
    input  wire logic [WIDE_W-1:0]   wide_irq_period_in,
    input  wire logic                narrow_en_in,
    input  wire logic                narrow_slow_in,
    input  wire logic [1:0]          narrow_div_sel_in,
    input  wire logic [NARROW_W-1:0] narrow_period_in,
    input  wire logic [NARROW_W-1:0] narrow_duty_first_in,
    input  wire logic [NARROW_W-1:0] narrow_duty_second_in,
    input  wire logic [NARROW_W-1:0] narrow_duty_third_in,
    output logic                     wide_wave_first_out,
    output logic                     wide_wave_second_out,
    output logic                     wide_irq_out,
    output logic                     narrow_wave_first_out,
    output logic                     narrow_wave_second_out,
    output logic                     narrow_wave_third_out
);

    // ----------------------------------------------------------------
    // helper: divided tick from a free-running prescaler
    // ----------------------------------------------------------------
    function automatic logic dpt_div_tick(input dpt_pkg::dpt_pre_t cnt,
                                          input logic [1:0] sel);
        logic res;
        res = 1'b0;
        unique case (sel)
            2'h0: res = 1'b1;
            2'h1: res = cnt[0];
            2'h2: res = &cnt[1:0];
            2'h3: res = &cnt[2:0];
        endcase
        return res;
    endfunction : dpt_div_tick

    // ----------------------------------------------------------------
    // prescalers
    // ----------------------------------------------------------------
    dpt_pkg::dpt_pre_t pre_reg;
    dpt_pkg::dpt_pre_t pre_next;
    dpt_pkg::dpt_pre_t slow_pre_reg;
    dpt_pkg::dpt_pre_t slow_pre_next;
    logic              wide_tick;
    logic              narrow_tick;

    // fast prescaler runs every clock, slow one on slow ticks
    always_comb begin
        pre_next      = pre_reg + 3'h1;
        slow_pre_next = slow_pre_reg;
        if (slow_tick_in) begin
            slow_pre_next = slow_pre_reg + 3'h1;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pre_reg      <= `DPT_RST_PRE;
            slow_pre_reg <= `DPT_RST_PRE;
        end else begin
            pre_reg      <= pre_next;
            slow_pre_reg <= slow_pre_next;
        end
    end

    // source tick selection for both timers
    always_comb begin
        if (wide_src_sel_in[`DPT_SEL_MSB]) begin
            wide_tick = slow_tick_in;
        end else begin
            wide_tick = dpt_div_tick(pre_reg, wide_src_sel_in[1:0]);
        end
        if (narrow_slow_in) begin
            narrow_tick = slow_tick_in && dpt_div_tick(slow_pre_reg, narrow_div_sel_in);
        end else begin
            narrow_tick = dpt_div_tick(pre_reg, narrow_div_sel_in);
        end
    end

    // ----------------------------------------------------------------
    // wide timer: shared high/low wave
    // ----------------------------------------------------------------
    dpt_pkg::dpt_wide_e wide_state_reg;
    dpt_pkg::dpt_wide_e wide_state_next;
    logic [WIDE_W-1:0]  wide_cnt_reg;
    logic [WIDE_W-1:0]  wide_cnt_next;
    logic               wide_wave_reg;
    logic               wide_wave_next;

    // phase sequencing, counting down each reload to zero
    always_comb begin
        wide_state_next = wide_state_reg;
        wide_cnt_next   = wide_cnt_reg;
        wide_wave_next  = wide_wave_reg;
        if (!wide_en_in) begin
            wide_state_next = dpt_pkg::DPT_WIDE_IDLE;
            wide_cnt_next   = `DPT_RST_WIDE_CNT;
            wide_wave_next  = 1'b0;
        end else begin
            unique case (wide_state_reg)
                dpt_pkg::DPT_WIDE_IDLE: begin
                    wide_state_next = dpt_pkg::DPT_WIDE_HIGH;
                    wide_cnt_next   = wide_high_in;
                    wide_wave_next  = 1'b1;
                end
                dpt_pkg::DPT_WIDE_HIGH: begin
                    if (wide_tick) begin
                        if (wide_cnt_reg == '0) begin
                            wide_state_next = dpt_pkg::DPT_WIDE_LOW;
                            wide_cnt_next   = wide_low_in;
                            wide_wave_next  = 1'b0;
                        end else begin
                            wide_cnt_next = wide_cnt_reg - 1'b1;
                        end
                    end
                end
                dpt_pkg::DPT_WIDE_LOW: begin
                    if (wide_tick) begin
                        if (wide_cnt_reg == '0) begin
                            wide_state_next = dpt_pkg::DPT_WIDE_HIGH;
                            wide_cnt_next   = wide_high_in;
                            wide_wave_next  = 1'b1;
                        end else begin
                            wide_cnt_next = wide_cnt_reg - 1'b1;
                        end
                    end
                end
                default: begin
                    wide_state_next = dpt_pkg::DPT_WIDE_IDLE;
                    wide_cnt_next   = `DPT_RST_WIDE_CNT;
                    wide_wave_next  = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wide_state_reg <= dpt_pkg::DPT_WIDE_IDLE;
            wide_cnt_reg   <= `DPT_RST_WIDE_CNT;
            wide_wave_reg  <= 1'b0;
        end else begin
            wide_state_reg <= wide_state_next;
            wide_cnt_reg   <= wide_cnt_next;
            wide_wave_reg  <= wide_wave_next;
        end
    end

    // one wave drives both pins
    assign wide_wave_first_out  = wide_wave_reg;
    assign wide_wave_second_out = wide_wave_reg;

    // ----------------------------------------------------------------
    // wide timer: interrupt timer
    // ----------------------------------------------------------------
    logic [WIDE_W-1:0] irq_cnt_reg;
    logic [WIDE_W-1:0] irq_cnt_next;
    logic              irq_reg;
    logic              irq_next;

    // own down counter, pulses a request at each end
    always_comb begin
        irq_cnt_next = irq_cnt_reg;
        irq_next     = 1'b0;
        if (!wide_irq_en_in) begin
            irq_cnt_next = wide_irq_period_in;
        end else if (wide_tick) begin
            if (irq_cnt_reg == '0) begin
                irq_next     = 1'b1;
                irq_cnt_next = wide_irq_period_in;
            end else begin
                irq_cnt_next = irq_cnt_reg - 1'b1;
            end
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            irq_cnt_reg <= `DPT_RST_WIDE_CNT;
            irq_reg     <= 1'b0;
        end else begin
            irq_cnt_reg <= irq_cnt_next;
            irq_reg     <= irq_next;
        end
    end

    assign wide_irq_out = irq_reg;

    // ----------------------------------------------------------------
    // narrow timer: common counter and three duties
    // ----------------------------------------------------------------
    logic [NARROW_W-1:0] narrow_cnt_reg;
    logic [NARROW_W-1:0] narrow_cnt_next;
    logic [2:0]          narrow_wave_reg;
    logic [2:0]          narrow_wave_next;
    logic [NARROW_W-1:0] narrow_per;
    logic [NARROW_W-1:0] narrow_duty [3];

    // short periods are raised to the two-tick minimum
    assign narrow_per = (narrow_period_in < `DPT_NARROW_MIN_PER) ?
                        `DPT_NARROW_MIN_PER : narrow_period_in;
    assign narrow_duty[0] = narrow_duty_first_in;
    assign narrow_duty[1] = narrow_duty_second_in;
    assign narrow_duty[2] = narrow_duty_third_in;

    // count 0..period-1, each output high while count below its duty
    always_comb begin
        narrow_cnt_next  = narrow_cnt_reg;
        narrow_wave_next = 3'h0;
        if (narrow_en_in) begin
            if (narrow_tick) begin
                if (narrow_cnt_reg >= narrow_per - 1'b1) begin
                    narrow_cnt_next = `DPT_RST_NARROW_CNT;
                end else begin
                    narrow_cnt_next = narrow_cnt_reg + 1'b1;
                end
            end
            for (int i = 0; i < 3; i++) begin
                narrow_wave_next[i] = narrow_cnt_next < narrow_duty[i];
            end
        end else begin
            narrow_cnt_next = `DPT_RST_NARROW_CNT;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            narrow_cnt_reg  <= `DPT_RST_NARROW_CNT;
            narrow_wave_reg <= 3'h0;
        end else begin
            narrow_cnt_reg  <= narrow_cnt_next;
            narrow_wave_reg <= narrow_wave_next;
        end
    end

    assign narrow_wave_first_out  = narrow_wave_reg[0];
    assign narrow_wave_second_out = narrow_wave_reg[1];
    assign narrow_wave_third_out  = narrow_wave_reg[2];

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking dpt_cb @(posedge clk_in);
    endclocking
    default disable iff (!rst_n_in);

    sequence s_high_end;
        wide_en_in && wide_state_reg == dpt_pkg::DPT_WIDE_HIGH && wide_tick && wide_cnt_reg == '0;
    endsequence

    sequence s_low_end;
        wide_en_in && wide_state_reg == dpt_pkg::DPT_WIDE_LOW && wide_tick && wide_cnt_reg == '0;
    endsequence

    sequence s_irq_end;
        wide_irq_en_in && wide_tick && irq_cnt_reg == '0;
    endsequence

    a_wide_same_out: assert property (wide_wave_first_out == wide_wave_second_out)
        else $error("wide outputs differ");

    a_wide_start_high: assert property (
        wide_en_in && wide_state_reg == dpt_pkg::DPT_WIDE_IDLE |=>
        wide_wave_first_out && wide_cnt_reg == $past(wide_high_in))
        else $error("wide wave did not start high");

    a_wide_high_end: assert property (s_high_end |=>
        !wide_wave_first_out && wide_cnt_reg == $past(wide_low_in))
        else $error("high phase end wrong");

    a_wide_low_end: assert property (s_low_end |=>
        wide_wave_first_out && wide_state_reg == dpt_pkg::DPT_WIDE_HIGH)
        else $error("low phase end wrong");

    a_wide_count_down: assert property (
        wide_en_in && wide_tick && wide_state_reg != dpt_pkg::DPT_WIDE_IDLE && wide_cnt_reg != '0 |=>
        wide_cnt_reg == $past(wide_cnt_reg) - 16'h0001 && $stable(wide_wave_reg))
        else $error("wide counter step wrong");

    a_irq_fire: assert property (s_irq_end |=>
        wide_irq_out && irq_cnt_reg == $past(wide_irq_period_in))
        else $error("interrupt not raised or not reloaded");

    a_irq_cause: assert property (wide_irq_out |-> $past(irq_cnt_reg) == '0 && $past(wide_tick))
        else $error("interrupt without period end");

    a_narrow_wrap: assert property (
        narrow_en_in && narrow_tick && narrow_cnt_reg >= narrow_per - 1'b1 |=> narrow_cnt_reg == '0)
        else $error("narrow counter did not wrap");

    a_narrow_duty_ends: assert property (
        narrow_en_in && narrow_duty_first_in == '0 ##1 narrow_en_in && $stable(narrow_duty_first_in) |->
        !narrow_wave_first_out ##1 1'b1)
        else $error("zero duty output went high");

    a_narrow_div8: assert property (
        !narrow_slow_in && narrow_div_sel_in == 2'h3 && narrow_tick |-> pre_reg == 3'h7)
        else $error("narrow divide by eight misaligned");

endmodule : dpt_top

// ==== tb/dpt_top_tb.sv ====
`timescale 1ns/1ns

module dpt_top_tb;

    // ----------------------------------------------------------------
    // stimulus and observed signals
    // ----------------------------------------------------------------
    logic        clk_in                 = 1'b0;
    logic        rst_n_in               = 1'b0;
    logic        slow_tick_in           = 1'b0;
    logic        wide_en_in             = 1'b0;
    logic [2:0]  wide_src_sel_in        = 3'h0;
    logic [15:0] wide_high_in           = 16'h0000;
    logic [15:0] wide_low_in            = 16'h0000;
    logic        wide_irq_en_in         = 1'b0;
    logic [15:0] wide_irq_period_in     = 16'h0000;
    logic        narrow_en_in           = 1'b0;
    logic        narrow_slow_in         = 1'b0;
    logic [1:0]  narrow_div_sel_in      = 2'h0;
    logic [13:0] narrow_period_in       = 14'h0000;
    logic [13:0] narrow_duty_first_in   = 14'h0000;
    logic [13:0] narrow_duty_second_in  = 14'h0000;
    logic [13:0] narrow_duty_third_in   = 14'h0000;
    logic        wide_wave_first_out;
    logic        wide_wave_second_out;
    logic        wide_irq_out;
    logic        narrow_wave_first_out;
    logic        narrow_wave_second_out;
    logic        narrow_wave_third_out;
    logic [2:0]  slow_cnt               = 3'h0;
    int          bad_count              = 0;
    int          check_count            = 0;

    // clock and a slow tick every five cycles
    always #25 clk_in = ~clk_in;
    always @(posedge clk_in) begin
        slow_cnt     <= (slow_cnt == 3'h4) ? 3'h0 : slow_cnt + 3'h1;
        slow_tick_in <= (slow_cnt == 3'h4);
    end

    dpt_top uut (
        .clk_in                 (clk_in),
        .rst_n_in               (rst_n_in),
        .slow_tick_in           (slow_tick_in),
        .wide_en_in             (wide_en_in),
        .wide_src_sel_in        (wide_src_sel_in),
        .wide_high_in           (wide_high_in),
        .wide_low_in            (wide_low_in),
        .wide_irq_en_in         (wide_irq_en_in),
        .wide_irq_period_in     (wide_irq_period_in),
        .narrow_en_in           (narrow_en_in),
        .narrow_slow_in         (narrow_slow_in),
        .narrow_div_sel_in      (narrow_div_sel_in),
        .narrow_period_in       (narrow_period_in),
        .narrow_duty_first_in   (narrow_duty_first_in),
        .narrow_duty_second_in  (narrow_duty_second_in),
        .narrow_duty_third_in   (narrow_duty_third_in),
        .wide_wave_first_out    (wide_wave_first_out),
        .wide_wave_second_out   (wide_wave_second_out),
        .wide_irq_out           (wide_irq_out),
        .narrow_wave_first_out  (narrow_wave_first_out),
        .narrow_wave_second_out (narrow_wave_second_out),
        .narrow_wave_third_out  (narrow_wave_third_out)
    );

    // ----------------------------------------------------------------
    // shared helpers
    // ----------------------------------------------------------------
    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : stop_test

    task automatic check(input logic [31:0] seen, input logic [31:0] expd);
        check_count++;
        if (seen !== expd) begin
            bad_count++;
            $display("MISMATCH t=%0t seen=%h expected=%h", $time, seen, expd);
        end
    endtask : check

    function automatic logic pick(input int i);
        case (i)
            0: pick = wide_wave_first_out;
            1: pick = wide_irq_out;
            2: pick = narrow_wave_first_out;
            3: pick = narrow_wave_second_out;
            default: pick = narrow_wave_third_out;
        endcase
    endfunction : pick

    // count settled samples until the output reaches lvl, bounded
    task automatic wait_lvl(input int i, input logic lvl, output int n);
        n = 0;
        while (pick(i) !== lvl) begin
            if (i == 0) check(wide_wave_second_out, wide_wave_first_out);
            n++;
            if (n > 3000) begin
                bad_count++;
                stop_test();
            end
            @(negedge clk_in);
        end
    endtask : wait_lvl

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic wide_case(input logic [2:0] sel, input int m, input int n, input int dv);
        int c;
        @(posedge clk_in);
        wide_en_in      <= 1'b0;
        wide_src_sel_in <= sel;
        wide_high_in    <= 16'(m);
        wide_low_in     <= 16'(n);
        repeat (2) @(posedge clk_in);
        wide_en_in      <= 1'b1;
        @(negedge clk_in);
        wait_lvl(0, 1'b1, c);
        wait_lvl(0, 1'b0, c);
        wait_lvl(0, 1'b1, c);
        check(c, (n + 1) * dv);
        wait_lvl(0, 1'b0, c);
        check(c, (m + 1) * dv);
    endtask : wide_case

    task automatic irq_case(input logic [2:0] sel, input int on, input int dv);
        int c;
        @(posedge clk_in);
        wide_irq_en_in     <= 1'b0;
        wide_src_sel_in    <= sel;
        wide_irq_period_in <= 16'(on);
        repeat (2) @(posedge clk_in);
        wide_irq_en_in     <= 1'b1;
        @(negedge clk_in);
        wait_lvl(1, 1'b1, c);
        wait_lvl(1, 1'b0, c);
        check(c, 1);
        wait_lvl(1, 1'b1, c);
        check(c + 1, (on + 1) * dv);
    endtask : irq_case

    task automatic irq_off();
        int c;
        @(posedge clk_in);
        wide_irq_en_in <= 1'b0;
        @(negedge clk_in);
        @(negedge clk_in);
        c = 0;
        repeat (60) begin
            @(negedge clk_in);
            c += int'(wide_irq_out !== 1'b0);
        end
        check(c, 0);
    endtask : irq_off

    // highs over four whole periods give the duty of each output
    task automatic narrow_case(input logic slow, input logic [1:0] dsel, input int p,
                               input int d1, input int d2, input int d3, input int tk);
        int ep;
        int c [3];
        ep = (p < 2) ? 2 : p;
        c  = '{0, 0, 0};
        @(posedge clk_in);
        narrow_en_in          <= 1'b0;
        narrow_slow_in        <= slow;
        narrow_div_sel_in     <= dsel;
        narrow_period_in      <= 14'(p);
        narrow_duty_first_in  <= 14'(d1);
        narrow_duty_second_in <= 14'(d2);
        narrow_duty_third_in  <= 14'(d3);
        @(posedge clk_in);
        @(negedge clk_in);
        check(narrow_wave_first_out, 1'b0);
        check(narrow_wave_second_out, 1'b0);
        check(narrow_wave_third_out, 1'b0);
        @(posedge clk_in);
        narrow_en_in          <= 1'b1;
        repeat (2 * ep * tk + 2) @(negedge clk_in);
        repeat (4 * ep * tk) begin
            @(negedge clk_in);
            for (int i = 0; i < 3; i++) c[i] += (pick(i + 2) === 1'b1) ? 1 : ((pick(i + 2) === 1'b0) ? 0 : 100000);
        end
        check(c[0], 4 * tk * ((d1 < ep) ? d1 : ep));
        check(c[1], 4 * tk * ((d2 < ep) ? d2 : ep));
        check(c[2], 4 * tk * ((d3 < ep) ? d3 : ep));
    endtask : narrow_case

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (12) @(posedge clk_in);
        rst_n_in <= 1'b1;
        @(posedge clk_in);
        wide_case(3'h0, 1, 0, 1);
        wide_case(3'h0, 0, 0, 1);
        wide_case(3'h1, 2, 1, 2);
        wide_case(3'h2, 0, 3, 4);
        wide_case(3'h3, 1, 1, 8);
        wide_case(3'h4, 1, 0, 5);
        wide_case(3'h7, 0, 2, 5);
        irq_case(3'h0, 3, 1);
        irq_case(3'h2, 2, 4);
        irq_case(3'h4, 1, 5);
        irq_off();
        narrow_case(1'b0, 2'h0, 3, 1, 0, 5, 1);
        narrow_case(1'b0, 2'h1, 1, 1, 2, 0, 2);
        narrow_case(1'b0, 2'h2, 6, 0, 3, 7, 4);
        narrow_case(1'b0, 2'h3, 5, 2, 4, 5, 8);
        narrow_case(1'b1, 2'h0, 4, 1, 2, 3, 5);
        narrow_case(1'b1, 2'h1, 2, 1, 0, 2, 10);
        stop_test();
    end

endmodule : dpt_top_tb
